// file: logic/ijr_ctrl.sv
// JTAG pin enable, reset sequencing and power gating control
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Power-mode-B bits 2..6 set to 1 cut control inputs from the array.
// - Auto power-down counts steady strobe at polarity; power-down after 15.
// - Power-up reset loads configuration, clears registers, flash operating.
// - After reset release wait recovery time before first memory access.
// - Flash state machine starts in read mode.
// - Reset aborts program or erase, flash back to read in bounded time.
// - Array outputs valid in warm reset; after config load at power-on.
// - In power-down array outputs follow inputs, address inputs blocked.
// - Macrocells cleared at power-on; own equations in warm reset, sleep.
// - Mapping register loaded from config on resets, two bits forced zero.
// - JTAG enable is OR of config bit, register bit, product term.
// - Enabled pins are inputs; data-out drives only after enable command.
// - Without JTAG enable the four pins are general-purpose I/O.
// - Run-time enable bit at offset C7h; reset or software clears it.
// - Reset spares JTAG if config-dedicated, else blocks and aborts it.
// - Blank device enables the four JTAG pins by default.
// - Status and error pins enabled only by the enable command.
// - Error pin low on failure until clear, or reset after disable.
// - Status pin high in read mode, low when busy or secondary write.
// - Enable command may pick open-drain drive for status and error.
// - Only configuration commands; no boundary-scan instructions.
// - Counter uses address strobe alone, not gated with write strobe or byte enable.
// - Both power-mode registers cleared at power-up only.
// - Enable register bit 0 holds run-time enable; others read zero.
module ijr_ctrl (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        warm_reset_n,
	input  wire logic        cfg_jtag_dedicated,
	input  wire logic        cfg_blank,
	input  wire logic [7:0]  cfg_memory_map,
	input  wire logic        jtag_select_term,
	input  wire logic        io_select,
	input  wire logic [7:0]  bus_addr,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata,
	input  wire logic        write_strobe_input,
	input  wire logic        bus_control_input_1,
	input  wire logic        bus_control_input_2,
	input  wire logic        address_latch_strobe,
	input  wire logic        data_byte_enable,
	input  wire logic        pld_input_clock,
	input  wire logic [15:0] addr_in,
	output logic      [4:0]  pld_ctrl,
	output logic      [15:0] pld_addr,
	output logic             pld_outputs_valid,
	output logic             mcell_clear,
	output logic             mcell_equation_reset,
	output logic             power_down_request,
	output logic             access_ready,
	output logic             flash_operating,
	output logic             mcu_io_input_mode,
	output logic             ports_tristate,
	output logic      [7:0]  memory_mapping_register,
	input  wire logic        flash_start,
	input  wire logic        flash_done,
	input  wire logic        flash_fail,
	input  wire logic        secondary_write,
	output logic             flash_read_mode,
	output logic             flash_abort,
	input  wire logic [5:0]  gpio_out,
	input  wire logic [5:0]  gpio_oe,
	output logic      [5:0]  gpio_in,
	input  wire logic [5:0]  pin_in,
	output logic      [5:0]  pin_out,
	output logic      [5:0]  pin_oe,
	output logic             jtag_on
);
	typedef struct packed {
		logic [5:0]           pin_s1;
		logic [5:0]           pin_s2;
		logic                 tck_q;
		logic [4:0]           ctl_s1;
		logic [4:0]           ctl_s2;
		logic [15:0]          adr_s1;
		logic [15:0]          adr_s2;
		logic                 ck_s1;
		logic                 ck_s2;
		logic                 ck_q;
		logic                 wr_s1;
		logic                 wr_s2;
		ijr_pkg::ijr_phase_t  ph;
		logic [7:0]           cnt;
		logic [7:0]           pma;
		logic [7:0]           pmb;
		logic                 jen;
		logic [7:0]           vm;
		logic [7:0]           rdata;
		ijr_pkg::ijr_flash_t  fl;
		logic [7:0]           fcnt;
		logic                 fabort;
		logic                 err;
		logic                 dis_seen;
		logic                 chan;
		logic                 ext;
		logic                 od;
		logic                 on;
		logic [5:0]           pout;
		logic [5:0]           poe;
		logic [5:0]           gin;
		logic [4:0]           pctl;
		logic [15:0]          padr;
		logic                 loaded;
	} ijr_ctrl_state_t;

	ijr_ctrl_state_t r;
	ijr_ctrl_state_t next_r;
	logic [7:0]      tap_ir;
	logic            tap_upd;
	logic            tap_tdo;
	logic            apd_pd;
	logic            in_reset;
	logic            tap_hold;

	// Open-drain slots float high, so only the low level is driven
	function automatic logic [1:0] ext_drive(logic level, logic od);
		ext_drive = od ? {1'b0, ~level} : {level, 1'b1};
	endfunction : ext_drive

	////////////////////////////////////////////////////////////////////////
	assign in_reset = r.ph != ijr_pkg::PH_RUN;
	// Dedicated pins keep scanning through any reset
	assign tap_hold = !r.on || (in_reset && !cfg_jtag_dedicated);

	ijr_tap u_tap (
		.clk       (clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.tck_rise  (r.pin_s2[ijr_pkg::PIN_CLOCK] && !r.tck_q),
		.tck_fall  (!r.pin_s2[ijr_pkg::PIN_CLOCK] && r.tck_q),
		.tms       (r.pin_s2[ijr_pkg::PIN_MODE]),
		.tdi       (r.pin_s2[ijr_pkg::PIN_DIN]),
		.hold_reset(tap_hold),
		.ir        (tap_ir),
		.update_ir (tap_upd),
		.tdo       (tap_tdo)
	);

	ijr_apd u_apd (
		.clk       (clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.pld_input_clock_rise(r.ck_s2 && !r.ck_q),
		.strobe    (r.ctl_s2[3]),
		.enable    (r.pma[ijr_pkg::PMA_APD_BIT]),
		.polarity  (r.pma[ijr_pkg::PMA_ALE_POL_BIT]),
		.power_down(apd_pd)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [1:0] drv;
		drv = 2'b00;
		next_r = r;
		next_r.pin_s1 = pin_in;
		next_r.pin_s2 = r.pin_s1;
		next_r.tck_q = r.pin_s2[ijr_pkg::PIN_CLOCK];
		next_r.ctl_s1 = {data_byte_enable, address_latch_strobe,
			bus_control_input_2, bus_control_input_1, write_strobe_input};
		next_r.ctl_s2 = r.ctl_s1;
		next_r.adr_s1 = addr_in;
		next_r.adr_s2 = r.adr_s1;
		next_r.ck_s1 = pld_input_clock;
		next_r.ck_s2 = r.ck_s1;
		next_r.ck_q = r.ck_s2;
		next_r.wr_s1 = warm_reset_n;
		next_r.wr_s2 = r.wr_s1;
		next_r.fabort = 1'b0;

		// Reset sequencing
		case (r.ph)
			ijr_pkg::PH_LOAD:
			begin
				next_r.cnt = r.cnt + 8'h01;
				if (r.cnt + 8'h01 >= ijr_pkg::CFG_LOAD_CYC)
				begin
					next_r.loaded = 1'b1;
					next_r.ph = ijr_pkg::PH_RECOVER;
					next_r.cnt = 8'h00;
				end
			end
			ijr_pkg::PH_RECOVER:
			begin
				next_r.cnt = r.cnt + 8'h01;
				if (!r.wr_s2)
					next_r.ph = ijr_pkg::PH_WARM;
				else if (r.cnt + 8'h01 >= ijr_pkg::OPR_CYC)
					next_r.ph = ijr_pkg::PH_RUN;
			end
			ijr_pkg::PH_RUN:
				if (!r.wr_s2)
					next_r.ph = ijr_pkg::PH_WARM;
			ijr_pkg::PH_WARM:
			begin
				next_r.cnt = 8'h00;
				if (r.wr_s2)
					next_r.ph = ijr_pkg::PH_RECOVER;
			end
			default: next_r.ph = ijr_pkg::PH_LOAD;
		endcase

		// Register side effects of reset; power modes survive warm reset
		if (r.ph == ijr_pkg::PH_LOAD || r.ph == ijr_pkg::PH_WARM)
		begin
			next_r.jen = 1'b0;
			next_r.vm = cfg_memory_map;
			next_r.vm[ijr_pkg::VM_DATA_CODE_BIT] = 1'b0;
			next_r.vm[ijr_pkg::VM_PERIPH_BIT] = 1'b0;
		end

		// Register access, refused until recovery has run out
		next_r.rdata = 8'h00;
		if (io_select && !in_reset && bus_wr)
			case (bus_addr)
				ijr_pkg::JTAG_PIN_ENABLE_OFS:
					next_r.jen = bus_wdata[ijr_pkg::JEN_BIT];
				ijr_pkg::POWER_MODE_A_OFS:    next_r.pma = bus_wdata;
				ijr_pkg::POWER_MODE_B_OFS:    next_r.pmb = bus_wdata;
				ijr_pkg::MEMORY_MAP_OFS:      next_r.vm = bus_wdata;
				default:                      next_r.rdata = 8'h00;
			endcase
		if (io_select && !in_reset && bus_rd)
			case (bus_addr)
				ijr_pkg::JTAG_PIN_ENABLE_OFS:
					next_r.rdata = {7'h00, r.jen};
				ijr_pkg::POWER_MODE_A_OFS:    next_r.rdata = r.pma;
				ijr_pkg::POWER_MODE_B_OFS:    next_r.rdata = r.pmb;
				ijr_pkg::MEMORY_MAP_OFS:      next_r.rdata = r.vm;
				default:                      next_r.rdata = 8'h00;
			endcase

		// Flash state machine
		case (r.fl)
			ijr_pkg::FL_READ:
				if (flash_start && !in_reset)
					next_r.fl = ijr_pkg::FL_BUSY;
			ijr_pkg::FL_BUSY:
				if (in_reset)
				begin
					next_r.fl = ijr_pkg::FL_ABORT;
					next_r.fabort = 1'b1;
					next_r.fcnt = 8'h00;
				end
				else if (flash_done || flash_fail)
					next_r.fl = ijr_pkg::FL_READ;
			ijr_pkg::FL_ABORT:
			begin
				next_r.fcnt = r.fcnt + 8'h01;
				if (r.fcnt + 8'h01 >= ijr_pkg::ABORT_CYC)
					next_r.fl = ijr_pkg::FL_READ;
			end
			default: next_r.fl = ijr_pkg::FL_READ;
		endcase

		// Configuration commands
		if (tap_upd)
			case (tap_ir)
				ijr_pkg::CMD_CFG_ENABLE:
				begin
					next_r.chan = 1'b1;
					next_r.ext = 1'b0;
					next_r.dis_seen = 1'b0;
				end
				ijr_pkg::CMD_CFG_ENABLE_EXT, ijr_pkg::CMD_CFG_ENABLE_EXT_OD:
				begin
					next_r.chan = 1'b1;
					next_r.ext = 1'b1;
					next_r.od = tap_ir == ijr_pkg::CMD_CFG_ENABLE_EXT_OD;
					next_r.dis_seen = 1'b0;
				end
				ijr_pkg::CMD_CFG_CLEAR:   next_r.err = 1'b0;
				ijr_pkg::CMD_CFG_DISABLE:
				begin
					next_r.chan = 1'b0;
					next_r.ext = 1'b0;
					next_r.dis_seen = 1'b1;
				end
				default: next_r.chan = r.chan;
			endcase
		if (tap_hold)
		begin
			next_r.chan = 1'b0;
			next_r.ext = 1'b0;
		end
		if (r.dis_seen && r.ph == ijr_pkg::PH_WARM)
			next_r.err = 1'b0;
		if (flash_fail && r.fl == ijr_pkg::FL_BUSY)
			next_r.err = 1'b1;

		// Pin multiplexing
		next_r.on = cfg_jtag_dedicated | cfg_blank | r.jen
			| jtag_select_term;
		next_r.pout = gpio_out;
		next_r.poe = gpio_oe;
		if (r.on)
		begin
			next_r.poe[ijr_pkg::PIN_MODE] = 1'b0;
			next_r.poe[ijr_pkg::PIN_CLOCK] = 1'b0;
			next_r.poe[ijr_pkg::PIN_DIN] = 1'b0;
			next_r.poe[ijr_pkg::PIN_DOUT] = r.chan;
			next_r.pout[ijr_pkg::PIN_DOUT] = tap_tdo;
			if (r.ext)
			begin
				drv = ext_drive(r.fl == ijr_pkg::FL_READ && !secondary_write,
					r.od);
				next_r.pout[ijr_pkg::PIN_STATUS] = drv[1];
				next_r.poe[ijr_pkg::PIN_STATUS] = drv[0];
				drv = ext_drive(!r.err, r.od);
				next_r.pout[ijr_pkg::PIN_ERROR] = drv[1];
				next_r.poe[ijr_pkg::PIN_ERROR] = drv[0];
			end
		end
		next_r.gin = r.pin_s2;

		// Array inputs: gated controls, address blocked while asleep
		next_r.pctl = r.ctl_s2 & ~r.pmb[ijr_pkg::PMB_GATE_HI:
			ijr_pkg::PMB_GATE_LO];
		next_r.padr = apd_pd ? 16'h0000 : r.adr_s2;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			r <= '0;
			r.ph <= ijr_pkg::PH_LOAD;
			r.pma <= ijr_pkg::POWER_MODE_RESET;
			r.pmb <= ijr_pkg::POWER_MODE_RESET;
			r.jen <= ijr_pkg::JTAG_EN_RESET[0];
			r.fl <= ijr_pkg::FL_READ;
			r.wr_s1 <= 1'b1;
			r.wr_s2 <= 1'b1;
		end
		else if (clk_en)
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////////////
	assign bus_rdata               = r.rdata;
	assign pld_ctrl                = r.pctl;
	assign pld_addr                = r.padr;
	assign pld_outputs_valid       = r.loaded;
	assign mcell_clear             = r.ph == ijr_pkg::PH_LOAD;
	assign mcell_equation_reset    = apd_pd || r.ph == ijr_pkg::PH_WARM;
	assign power_down_request      = apd_pd;
	assign access_ready            = r.ph == ijr_pkg::PH_RUN;
	assign flash_operating         = r.loaded;
	assign mcu_io_input_mode       = in_reset;
	assign ports_tristate          = in_reset || apd_pd;
	assign memory_mapping_register = r.vm;
	assign flash_read_mode         = r.fl == ijr_pkg::FL_READ;
	assign flash_abort             = r.fabort;
	assign gpio_in                 = r.gin;
	assign pin_out                 = r.pout;
	assign pin_oe                  = r.poe;
	assign jtag_on                 = r.on;
endmodule : ijr_ctrl
`default_nettype wire

// file: logic/ijr_pkg.sv
// Shared constants and types of the JTAG enable and reset control block
`default_nettype none
package ijr_pkg;

	// Register offsets from the I/O block base
	localparam logic [7:0] JTAG_PIN_ENABLE_OFS  = 8'hc7;
	localparam logic [7:0] POWER_MODE_A_OFS     = 8'hb0;
	localparam logic [7:0] POWER_MODE_B_OFS     = 8'hb4;
	localparam logic [7:0] MEMORY_MAP_OFS       = 8'he2;

	// Field positions
	localparam int JEN_BIT          = 0;
	localparam int PMA_APD_BIT      = 1;
	localparam int PMA_ALE_POL_BIT  = 2;
	localparam int PMB_GATE_LO      = 2;
	localparam int PMB_GATE_HI      = 6;
	localparam int VM_DATA_CODE_BIT = 0;
	localparam int VM_PERIPH_BIT    = 7;

	// Reset values
	localparam logic [7:0] POWER_MODE_RESET = 8'h00;
	localparam logic [7:0] JTAG_EN_RESET    = 8'h00;

	// Port C pin slots
	localparam int PIN_MODE   = 0;
	localparam int PIN_CLOCK  = 1;
	localparam int PIN_STATUS = 2;
	localparam int PIN_ERROR  = 3;
	localparam int PIN_DIN    = 4;
	localparam int PIN_DOUT   = 5;

	// Configuration command codes, all values arbitrary
	localparam logic [7:0] CMD_CFG_ENABLE        = 8'h0c;
	localparam logic [7:0] CMD_CFG_ENABLE_EXT    = 8'h0d;
	localparam logic [7:0] CMD_CFG_ENABLE_EXT_OD = 8'h0e;
	localparam logic [7:0] CMD_CFG_CLEAR         = 8'h0f;
	localparam logic [7:0] CMD_CFG_DISABLE       = 8'h0a;
	localparam logic [7:0] CMD_BYPASS            = 8'hff;
	localparam logic [7:0] IR_CAPTURE            = 8'h01;

	// Timing
	localparam int CLK_PERIOD_NS      = 10;
	localparam int CFG_LOAD_TIME_NS   = 100;
	localparam int OPR_TIME_NS        = 200;
	localparam int ABORT_TIME_NS      = 250;
	localparam logic [7:0] CFG_LOAD_CYC =
		8'((CFG_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] OPR_CYC =
		8'((OPR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] ABORT_CYC = 8'(ABORT_TIME_NS / CLK_PERIOD_NS);
	localparam logic [3:0] APD_CLOCKS = 4'hf;

	typedef enum logic [1:0] {
		PH_LOAD    = 2'b00,
		PH_RECOVER = 2'b01,
		PH_RUN     = 2'b10,
		PH_WARM    = 2'b11
	} ijr_phase_t;

	typedef enum logic [1:0] {
		FL_READ  = 2'b00,
		FL_BUSY  = 2'b01,
		FL_ABORT = 2'b10
	} ijr_flash_t;

	typedef enum logic [3:0] {
		TAP_RESET   = 4'b0000, TAP_IDLE    = 4'b0001,
		TAP_SEL_DR  = 4'b0010, TAP_CAP_DR  = 4'b0011,
		TAP_SH_DR   = 4'b0100, TAP_EX1_DR  = 4'b0101,
		TAP_PAU_DR  = 4'b0110, TAP_EX2_DR  = 4'b0111,
		TAP_UPD_DR  = 4'b1000, TAP_SEL_IR  = 4'b1001,
		TAP_CAP_IR  = 4'b1010, TAP_SH_IR   = 4'b1011,
		TAP_EX1_IR  = 4'b1100, TAP_PAU_IR  = 4'b1101,
		TAP_EX2_IR  = 4'b1110, TAP_UPD_IR  = 4'b1111
	} ijr_tap_t;

endpackage : ijr_pkg
`default_nettype wire

// file: logic/ijr_tap.sv
// Configuration-only test access port driven by sampled clock edges
`timescale 1ns/10ps
`default_nettype none
module ijr_tap (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire logic       tck_rise,
	input  wire logic       tck_fall,
	input  wire logic       tms,
	input  wire logic       tdi,
	input  wire logic       hold_reset,
	output logic      [7:0] ir,
	output logic            update_ir,
	output logic            tdo
);
	typedef struct packed {
		ijr_pkg::ijr_tap_t st;
		logic [7:0]        ir_sh;
		logic [7:0]        ir;
		logic              byp;
		logic              upd;
		logic              tdo;
	} ijr_tap_state_t;

	ijr_tap_state_t r;
	ijr_tap_state_t next_r;

	function automatic ijr_pkg::ijr_tap_t step(ijr_pkg::ijr_tap_t s,
		logic m);
		case (s)
			ijr_pkg::TAP_RESET:  step = m ? ijr_pkg::TAP_RESET
				: ijr_pkg::TAP_IDLE;
			ijr_pkg::TAP_IDLE:   step = m ? ijr_pkg::TAP_SEL_DR
				: ijr_pkg::TAP_IDLE;
			ijr_pkg::TAP_SEL_DR: step = m ? ijr_pkg::TAP_SEL_IR
				: ijr_pkg::TAP_CAP_DR;
			ijr_pkg::TAP_CAP_DR, ijr_pkg::TAP_SH_DR:
				step = m ? ijr_pkg::TAP_EX1_DR : ijr_pkg::TAP_SH_DR;
			ijr_pkg::TAP_EX1_DR: step = m ? ijr_pkg::TAP_UPD_DR
				: ijr_pkg::TAP_PAU_DR;
			ijr_pkg::TAP_PAU_DR: step = m ? ijr_pkg::TAP_EX2_DR
				: ijr_pkg::TAP_PAU_DR;
			ijr_pkg::TAP_EX2_DR: step = m ? ijr_pkg::TAP_UPD_DR
				: ijr_pkg::TAP_SH_DR;
			ijr_pkg::TAP_SEL_IR: step = m ? ijr_pkg::TAP_RESET
				: ijr_pkg::TAP_CAP_IR;
			ijr_pkg::TAP_CAP_IR, ijr_pkg::TAP_SH_IR:
				step = m ? ijr_pkg::TAP_EX1_IR : ijr_pkg::TAP_SH_IR;
			ijr_pkg::TAP_EX1_IR: step = m ? ijr_pkg::TAP_UPD_IR
				: ijr_pkg::TAP_PAU_IR;
			ijr_pkg::TAP_PAU_IR: step = m ? ijr_pkg::TAP_EX2_IR
				: ijr_pkg::TAP_PAU_IR;
			ijr_pkg::TAP_EX2_IR: step = m ? ijr_pkg::TAP_UPD_IR
				: ijr_pkg::TAP_SH_IR;
			default:             step = m ? ijr_pkg::TAP_SEL_DR
				: ijr_pkg::TAP_IDLE;
		endcase
	endfunction : step

	always_comb
	begin
		next_r = r;
		next_r.upd = 1'b0;
		if (hold_reset)
		begin
			next_r.st = ijr_pkg::TAP_RESET;
			next_r.ir = ijr_pkg::CMD_BYPASS;
		end
		else if (tck_rise)
		begin
			next_r.st = step(r.st, tms);
			case (r.st)
				ijr_pkg::TAP_RESET:  next_r.ir = ijr_pkg::CMD_BYPASS;
				ijr_pkg::TAP_CAP_IR: next_r.ir_sh = ijr_pkg::IR_CAPTURE;
				ijr_pkg::TAP_SH_IR:  next_r.ir_sh = {tdi, r.ir_sh[7:1]};
				ijr_pkg::TAP_CAP_DR: next_r.byp = 1'b0;
				// Scan chains absent: every data scan goes through bypass
				ijr_pkg::TAP_SH_DR:  next_r.byp = tdi;
				ijr_pkg::TAP_UPD_IR:
				begin
					next_r.ir = r.ir_sh;
					next_r.upd = 1'b1;
				end
				default: next_r.byp = r.byp;
			endcase
		end
		else if (tck_fall)
			next_r.tdo = (r.st == ijr_pkg::TAP_SH_IR) ? r.ir_sh[0] : r.byp;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			r <= '{st: ijr_pkg::TAP_RESET, ir_sh: 8'h00,
				ir: ijr_pkg::CMD_BYPASS, byp: 1'b0, upd: 1'b0, tdo: 1'b0};
		else if (clk_en)
			r <= next_r;
	end

	assign ir        = r.ir;
	assign update_ir = r.upd;
	assign tdo       = r.tdo;
endmodule : ijr_tap
`default_nettype wire

// file: logic/ijr_apd.sv
// Automatic power-down counter on sampled input-clock edges
`timescale 1ns/10ps
`default_nettype none
module ijr_apd (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic clk_en,
	input  wire logic pld_input_clock_rise,
	input  wire logic strobe,
	input  wire logic enable,
	input  wire logic polarity,
	output logic      power_down
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       strobe_q;
		logic       pd;
	} ijr_apd_state_t;

	ijr_apd_state_t r;
	ijr_apd_state_t next_r;

	always_comb
	begin
		next_r = r;
		next_r.strobe_q = strobe;
		// A strobe edge means bus activity, so counting restarts
		if (!enable || strobe != polarity || strobe != r.strobe_q)
		begin
			next_r.cnt = 4'h0;
			next_r.pd = 1'b0;
		end
		else if (pld_input_clock_rise && r.cnt != ijr_pkg::APD_CLOCKS)
		begin
			next_r.cnt = r.cnt + 4'h1;
			next_r.pd = (r.cnt + 4'h1) == ijr_pkg::APD_CLOCKS;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			r <= '{cnt: 4'h0, strobe_q: 1'b0, pd: 1'b0};
		else if (clk_en)
			r <= next_r;
	end

	assign power_down = r.pd;
endmodule : ijr_apd
`default_nettype wire

// file: dv/ijr_properties.sv
// Port-level assertions for the JTAG enable and reset control block
`timescale 1ns/10ps
`default_nettype none
module ijr_properties (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        cfg_jtag_dedicated,
	input wire logic        cfg_blank,
	input wire logic        jtag_select_term,
	input wire logic        jtag_on,
	input wire logic [5:0]  pin_oe,
	input wire logic [15:0] pld_addr,
	input wire logic        power_down_request,
	input wire logic        access_ready,
	input wire logic        mcu_io_input_mode,
	input wire logic        ports_tristate,
	input wire logic        pld_outputs_valid,
	input wire logic        mcell_clear,
	input wire logic        flash_abort,
	input wire logic        flash_read_mode,
	input wire logic [7:0]  memory_mapping_register
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_src;
		cfg_jtag_dedicated || cfg_blank || jtag_select_term;
	endsequence
	sequence s_up;
		!access_ready ##1 access_ready;
	endsequence
	AST_JTAG_OR: assert property (s_src |-> ##[1:3] jtag_on)
		else $error("jtag enable missing");
	AST_PINS_IN: assert property ($rose(jtag_on) ##2 jtag_on
		|-> pin_oe[1:0] == 2'b00 && !pin_oe[4] && !pin_oe[5])
		else $error("jtag pins not inputs");
	AST_PD_ADDR: assert property (power_down_request [*2]
		|-> pld_addr == 16'h0000)
		else $error("address not blocked");
	AST_RECOVER: assert property (s_up |-> !$past(access_ready, 20))
		else $error("recovery too short");
	AST_RST_PINS: assert property (!access_ready
		|-> mcu_io_input_mode && ports_tristate)
		else $error("pins active in reset");
	AST_VALID: assert property (mcell_clear |-> !pld_outputs_valid)
		else $error("outputs valid during load");
	AST_ABORT: assert property (flash_abort |-> ##[1:30] flash_read_mode)
		else $error("abort not back to read");
	AST_VM: assert property (s_up |-> !memory_mapping_register[0]
		&& !memory_mapping_register[7])
		else $error("mapping bits not cleared");
endmodule : ijr_properties
bind ijr_ctrl ijr_properties u_ijr_properties (.*);
`default_nettype wire

// file: dv/ijr_jtag_host.sv
// Behavioural JTAG programming controller on the link pins
`timescale 1ns/10ps
`default_nettype none
module ijr_jtag_host (
	output logic tms,
	output logic tck,
	output logic tdi
);
	initial
	begin
		{tms, tck, tdi} = 3'b101;
	end
	// Clock stands low between frames; data line never keeps a stale level
	task automatic bit_io(input logic m, input logic d);
		{tms, tdi} = {m, d};
		#40 tck = 1'b1;
		#20 tdi = ~d;
		#20 tck = 1'b0;
	endtask : bit_io
	// Reset, walk to shift-IR, shift LSB first, update, idle
	task automatic send_cmd(input logic [7:0] cmd);
		int k;
		logic [9:0] walk;
		walk = 10'b0011011111;
		for (k = 0; k < 10; k++)
			bit_io(walk[k], 1'b0);
		for (k = 0; k < 8; k++)
			bit_io(k == 7, cmd[k]);
		bit_io(1'b1, 1'b0);
		bit_io(1'b0, 1'b0);
	endtask : send_cmd
endmodule : ijr_jtag_host
`default_nettype wire

// file: dv/isp_jtag_reset_control_bench.sv
// Self-checking bench for the JTAG enable and reset control block
`timescale 1ns/10ps
`default_nettype none
module isp_jtag_reset_control_bench;
	logic        clk, reset, clk_en, warm_reset_n, cfg_jtag_dedicated;
	logic        cfg_blank, jtag_select_term, io_select, bus_wr, bus_rd;
	logic        write_strobe_input, bus_control_input_1, bus_control_input_2;
	logic        address_latch_strobe, data_byte_enable, pld_input_clock;
	logic        pld_outputs_valid, mcell_clear, mcell_equation_reset;
	logic        power_down_request, access_ready, flash_operating;
	logic        mcu_io_input_mode, ports_tristate, flash_start, flash_done;
	logic        flash_fail, secondary_write, flash_read_mode, flash_abort;
	logic        jtag_on, tms, tck, tdi, seen;
	logic [4:0]  pld_ctrl;
	logic [7:0]  cfg_memory_map, bus_addr, bus_wdata, bus_rdata;
	logic [7:0]  memory_mapping_register, rd;
	logic [15:0] addr_in, pld_addr;
	logic [5:0]  gpio_out, gpio_oe, gpio_in, pin_in, pin_out, pin_oe;
	logic [7:0]  ta[4] = '{8'hc7, 8'hb0, 8'hb4, 8'h55};
	logic [7:0]  tm[4] = '{8'hff, 8'h06, 8'h7c, 8'hff};
	logic [7:0]  tk[4] = '{8'h01, 8'hff, 8'hff, 8'h00};
	int          n_mismatch, checks, j;
	int          mdl[int];
	// Status and error lines pulled up, as on a wired-OR board
	assign pin_in = (pin_oe & pin_out)
		| (~pin_oe & {1'b1, tdi, 2'b11, tck, tms});
	ijr_ctrl u_ijr_ctrl (.*);
	ijr_jtag_host u_ijr_jtag_host (.*);
	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		{io_select, bus_wr, bus_rd, bus_addr, bus_wdata} = {1'b1, w, ~w, a, d};
		cyc(1);
		rd = bus_rdata;
		{io_select, bus_wr, bus_rd} = 3'h0;
		cyc(1);
	endtask : bus
	task automatic wreg(input logic [7:0] a, d, k);
		bus(1'b1, a, d);
		mdl[a] = d & k;
	endtask : wreg
	task automatic rchk(input logic [7:0] a);
		bus(1'b0, a, 8'h00);
		chk(rd, mdl[a]);
	endtask : rchk
	task automatic pulse(input logic [2:0] s);
		{flash_start, flash_done, flash_fail} = s;
		cyc(1);
		{flash_start, flash_done, flash_fail} = 3'h0;
	endtask : pulse
	task automatic pclk(input int n);
		repeat (n)
		begin
			pld_input_clock = 1'b1;
			cyc(4);
			pld_input_clock = 1'b0;
			cyc(4);
		end
	endtask : pclk
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic await(input logic sel);
		for (int k = 0; k < 200; k++)
		begin
			if ((sel ? flash_read_mode : access_ready) === 1'b1)
				return;
			cyc(1);
		end
		n_mismatch++;
		$display("[FAIL] %0t wait ran out", $time);
		results();
	endtask : await
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		{clk_en, reset, warm_reset_n, write_strobe_input} = 4'hf;
		{cfg_jtag_dedicated, cfg_blank, jtag_select_term, io_select} = 4'h0;
		{bus_wr, bus_rd, flash_start, flash_done, flash_fail} = 5'h00;
		{secondary_write, bus_control_input_1, bus_control_input_2} = 3'h0;
		{address_latch_strobe, data_byte_enable, pld_input_clock} = 3'h0;
		{bus_addr, bus_wdata, addr_in, gpio_out, gpio_oe} = '0;
		{n_mismatch, checks} = '0;
		cfg_memory_map = 8'hff;
		void'($urandom(32'h4010));
		foreach (ta[j]) mdl[ta[j]] = 0;
		cyc(20);
		reset = 1'b0;
		cyc(5);
		chk(pld_outputs_valid, 1'b0);
		chk(mcell_clear, 1'b1);
		cyc(20);
		chk(access_ready, 1'b0);
		chk(pld_outputs_valid, 1'b1);
		chk(flash_operating, 1'b1);
		await(1'b0);
		chk(memory_mapping_register, 8'h7e);
		chk(flash_read_mode, 1'b1);
		foreach (ta[j]) rchk(ta[j]);
		repeat (2)
			foreach (ta[j])
			begin
				wreg(ta[j], 8'($urandom) & tm[j], tk[j]);
				rchk(ta[j]);
			end
		$display("register test done");
		wreg(8'hc7, 8'h00, 8'h01);
		{gpio_oe, gpio_out} = 12'($urandom);
		cyc(3);
		chk(jtag_on, 1'b0);
		chk(pin_oe, gpio_oe);
		cfg_blank = 1'b1;
		cyc(3);
		chk(jtag_on, 1'b1);
		cfg_blank = 1'b0;
		jtag_select_term = 1'b1;
		cyc(3);
		chk(jtag_on, 1'b1);
		wreg(8'hc7, 8'h01, 8'h01);
		jtag_select_term = 1'b0;
		cyc(3);
		chk(jtag_on, 1'b1);
		u_ijr_jtag_host.send_cmd(ijr_pkg::CMD_CFG_ENABLE_EXT);
		cyc(8);
		chk(pin_oe[5], 1'b1);
		chk(pin_in[2], 1'b1);
		pulse(3'h4);
		cyc(5);
		chk(pin_in[2], 1'b0);
		pulse(3'h1);
		await(1'b1);
		cyc(5);
		chk(pin_in[3], 1'b0);
		u_ijr_jtag_host.send_cmd(ijr_pkg::CMD_CFG_CLEAR);
		cyc(8);
		chk(pin_in[3], 1'b1);
		u_ijr_jtag_host.send_cmd(ijr_pkg::CMD_CFG_ENABLE_EXT_OD);
		cyc(8);
		pulse(3'h4);
		cyc(5);
		chk({pin_oe[2], pin_out[2]}, 2'b10);
		pulse(3'h2);
		await(1'b1);
		cyc(5);
		chk(pin_oe[2], 1'b0);
		$display("jtag test done");
		{data_byte_enable, address_latch_strobe, bus_control_input_2,
			bus_control_input_1, write_strobe_input} = 5'h1f;
		for (j = 0; j < 5; j++)
		begin
			wreg(8'hb4, 8'h04 << j, 8'hff);
			cyc(4);
			chk(pld_ctrl, 5'h1f & ~(5'h01 << j));
		end
		wreg(8'hb4, 8'h00, 8'hff);
		addr_in = 16'($urandom) | 16'h0001;
		wreg(8'hb0, 8'h06, 8'hff);
		pclk(14);
		chk(power_down_request, 1'b0);
		pclk(1);
		chk(power_down_request, 1'b1);
		chk(pld_addr, 16'h0000);
		address_latch_strobe = 1'b0;
		pclk(2);
		chk(power_down_request, 1'b0);
		wreg(8'hb0, 8'h02, 8'hff);
		pclk(15);
		chk(power_down_request, 1'b1);
		wreg(8'hb0, 8'h00, 8'hff);
		pclk(16);
		chk(power_down_request, 1'b0);
		$display("power test done");
		wreg(8'hb4, 8'h40, 8'hff);
		pulse(3'h4);
		cyc(1);
		pulse(3'h1);
		u_ijr_jtag_host.send_cmd(ijr_pkg::CMD_CFG_DISABLE);
		cyc(8);
		chk(pin_oe[5], 1'b0);
		pulse(3'h4);
		cyc(2);
		{warm_reset_n, seen} = 2'b00;
		for (j = 0; j < 10; j++)
		begin
			cyc(1);
			seen = seen | flash_abort;
		end
		chk(seen, 1'b1);
		chk(jtag_on, 1'b0);
		chk(pin_oe, gpio_oe);
		chk(mcell_equation_reset, 1'b1);
		chk(gpio_in, pin_in);
		warm_reset_n = 1'b1;
		mdl[8'hc7] = 0;
		await(1'b0);
		chk(flash_read_mode, 1'b1);
		chk(memory_mapping_register, 8'h7e);
		foreach (ta[j]) rchk(ta[j]);
		jtag_select_term = 1'b1;
		u_ijr_jtag_host.send_cmd(ijr_pkg::CMD_CFG_ENABLE_EXT);
		cyc(8);
		chk(pin_in[3], 1'b1);
		$display("warm reset test done");
		results();
	end
endmodule : isp_jtag_reset_control_bench
`default_nettype wire
